// *** core/adc_control.sv ***
// Purpose: register file, clock divider and result lock of the converter
// Assumes: AXI4-Lite slave, one clock, analog comparator outside
// Notes:
// Notes on behaviour
// RULE_01: setting converter-on starts continuous conversion of the selected channel
// RULE_02: clearing converter-on stops the converter and aborts any conversion
// RULE_03: each completion sets the done flag and offers the new result
// RULE_04: reading the high result register clears the done flag
// RULE_05: any write to the control/status register clears the done flag; here a write with lane 0 off leaves it set
// RULE_06: control bits 6..0 read/write; done bit read only, never set by write
// RULE_07: a channel change aborts, clears done and restarts on the new channel
// RULE_08: the four-bit channel field selects input 0 to 15 directly
// RULE_09: reading the low result register locks both result registers
// RULE_10: lock released by a high result read or clearing converter-on
// RULE_11: while locked no new result is loaded
// RULE_12: slow/speed pick cpu clock /2, /1, /4, /2; undivided only up to 4 MHz
// RULE_13: high register shows result 9..2; low shows 1..0, upper bits zero
// RULE_14: all three registers reset to zero
// RULE_15: software polls done, reads low, then high for ten bits
// RULE_16: software polls done, reads high only for eight bits
// RULE_17: the wait low-power mode leaves the converter untouched
// RULE_18: halt mode disables the converter; software waits out stabilisation
// RULE_19: inputs above or below the references saturate to all ones or zero
// RULE_20: sample phase and approximation length are fixed by parameters
`timescale 1ns/1ps
`default_nettype none
module adc_control #(
  parameter int SAMPLE_TICKS = adc_pkg::SAMPLE_TICKS_DEFAULT
) (
  input  wire logic                             CLOCK,
  input  wire logic                             RST_B,
  input  wire logic [adc_pkg::AXI_ADDR_W-1:0]   AWADDR,
  input  wire logic                             AWVALID,
  output logic                                  AWREADY,
  input  wire logic [adc_pkg::AXI_DATA_W-1:0]   WDATA,
  input  wire logic [3:0]                       WSTRB,
  input  wire logic                             WVALID,
  output logic                                  WREADY,
  output logic [1:0]                            BRESP,
  output logic                                  BVALID,
  input  wire logic                             BREADY,
  input  wire logic [adc_pkg::AXI_ADDR_W-1:0]   ARADDR,
  input  wire logic                             ARVALID,
  output logic                                  ARREADY,
  output logic [adc_pkg::AXI_DATA_W-1:0]        RDATA,
  output logic [1:0]                            RRESP,
  output logic                                  RVALID,
  input  wire logic                             RREADY,
  input  wire logic                             COMP_HIGH,
  input  wire logic                             HALT_MODE,
  output logic [3:0]                            CHANNEL_SELECT,
  output logic                                  CONVERTER_ENABLE,
  output logic                                  SAMPLE_HOLD,
  output logic [adc_pkg::RESULT_W-1:0]          DAC_CODE
);
  import adc_pkg::*;

  sar_if #(.W(RESULT_W)) sar ();

  logic                   awready_q;
  logic                   wready_q;
  logic                   arready_q;
  logic                   have_aw_q;
  logic                   have_w_q;
  logic [AXI_ADDR_W-1:0]  aw_addr_q;
  logic [7:0]             w_byte_q;
  logic                   w_lane0_q;
  logic                   bvalid_q;
  logic [1:0]             bresp_q;
  logic                   rvalid_q;
  logic [1:0]             rresp_q;
  logic [AXI_DATA_W-1:0]  rdata_q;
  logic [6:0]             ctrl_q;
  logic                   done_q;
  logic                   lock_q;
  logic [RESULT_W-1:0]    result_q;
  logic [1:0]             div_cnt_q;
  logic                   tick_q;
  logic                   en_q;
  logic [3:0]             chan_q;
  logic                   wr_commit;
  logic                   wr_csr;
  logic                   wr_hit;
  logic                   rd_take;
  logic                   rd_high;
  logic                   rd_low;
  logic                   chan_change;
  logic                   on_fall;
  logic                   done_accept;
  logic [1:0]             limit;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  function automatic logic addr_is(input logic [AXI_ADDR_W-1:0] a, input logic [11:0] reg_addr);
    addr_is = (a[AXI_ADDR_W-1:2] == reg_addr[11:2]);
  endfunction

  assign wr_commit   = have_aw_q && have_w_q && !bvalid_q;
  assign wr_hit      = addr_is(aw_addr_q, CSR_ADDR) || addr_is(aw_addr_q, HIGH_ADDR) || addr_is(aw_addr_q, LOW_ADDR);
  // a write with lane 0 off leaves the register and the flag alone
  assign wr_csr      = wr_commit && w_lane0_q && addr_is(aw_addr_q, CSR_ADDR);
  assign rd_take     = ARVALID && arready_q;
  assign rd_high     = rd_take && addr_is(ARADDR, HIGH_ADDR);
  assign rd_low      = rd_take && addr_is(ARADDR, LOW_ADDR);
  assign chan_change = wr_csr && (w_byte_q[CH_MSB:CH_LSB] != ctrl_q[CH_MSB:CH_LSB]);
  assign on_fall     = wr_csr && ctrl_q[ON_BIT] && !w_byte_q[ON_BIT];
  // a completion racing an abort belongs to the abandoned conversion
  assign done_accept = sar.done && en_q && !sar.restart;
  assign limit       = div_limit(ctrl_q[SLOW_BIT], ctrl_q[SPEED_BIT]);

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      have_aw_q <= 1'b0;
      have_w_q  <= 1'b0;
      aw_addr_q <= '0;
      w_byte_q  <= 8'h00;
      w_lane0_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      awready_q <= AWVALID && !awready_q && !have_aw_q && !bvalid_q;
      wready_q  <= WVALID && !wready_q && !have_w_q && !bvalid_q;
      if (AWVALID && awready_q) begin
        have_aw_q <= 1'b1;
        aw_addr_q <= AWADDR;
      end
      if (WVALID && wready_q) begin
        have_w_q  <= 1'b1;
        w_byte_q  <= WDATA[7:0];
        w_lane0_q <= WSTRB[0];
      end
      if (wr_commit) begin
        have_aw_q <= 1'b0;
        have_w_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= '0;
    end else begin
      arready_q <= ARVALID && !arready_q && !rvalid_q;
      if (rd_take) begin
        rvalid_q <= 1'b1;
        rresp_q  <= RESP_OKAY;
        if (addr_is(ARADDR, CSR_ADDR)) begin
          rdata_q <= {24'h00_0000, done_q, ctrl_q};
        end else if (addr_is(ARADDR, HIGH_ADDR)) begin
          rdata_q <= {24'h00_0000, result_q[9:2]}; // RULE_13
        end else if (addr_is(ARADDR, LOW_ADDR)) begin
          rdata_q <= {30'h0000_0000, result_q[1:0]}; // RULE_13
        end else begin
          rdata_q <= '0;
          rresp_q <= RESP_SLVERR;
        end
      end else if (rvalid_q && RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control/status register
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_q <= CTRL_RESET; // RULE_14
    end else if (wr_csr) begin
      ctrl_q <= w_byte_q[6:0]; // RULE_06
    end
  end

  // set wins over every clear in the same cycle
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      done_q <= 1'b0;
    end else if (done_accept) begin
      done_q <= 1'b1; // RULE_03
    end else if (wr_csr || rd_high) begin
      done_q <= 1'b0; // RULE_04 RULE_05 RULE_07
    end
  end

  // ----------------------------------------------------------------
  // result lock
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      lock_q <= 1'b0;
    end else if (rd_high || on_fall) begin
      lock_q <= 1'b0; // RULE_10
    end else if (rd_low) begin
      lock_q <= 1'b1; // RULE_09
    end
  end

  // a high read in the completion cycle already returned the old pair;
  // a low read in that cycle returned the old low bits, so the old pair stays
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      result_q <= RESULT_RESET; // RULE_14
    end else if (done_accept && ((!lock_q && !rd_low) || rd_high)) begin // RULE_09
      result_q <= sar.result; // RULE_11
    end
  end

  // ----------------------------------------------------------------
  // converter clock and enable
  // ----------------------------------------------------------------
  // undivided is out of range at this clock rate; software must not pick it above 4 MHz
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      div_cnt_q <= 2'h0;
      tick_q    <= 1'b0;
    end else if (div_cnt_q >= limit) begin
      div_cnt_q <= 2'h0;
      tick_q    <= 1'b1; // RULE_12
    end else begin
      div_cnt_q <= div_cnt_q + 2'h1;
      tick_q    <= 1'b0;
    end
  end

  // wait mode has no input here at all, halt stops the converter
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      en_q   <= 1'b0;
      chan_q <= 4'h0;
    end else begin
      en_q   <= ctrl_q[ON_BIT] && !HALT_MODE; // RULE_01 RULE_02 RULE_17 RULE_18
      chan_q <= ctrl_q[CH_MSB:CH_LSB]; // RULE_08
    end
  end

  assign sar.tick      = tick_q;
  assign sar.run       = en_q && ctrl_q[ON_BIT]; // RULE_02
  assign sar.restart   = chan_change || on_fall; // RULE_07
  assign sar.comp_high = COMP_HIGH;

  sar_sequencer #(
    .SAMPLE_TICKS (SAMPLE_TICKS)
  ) u_seq (
    .clock (CLOCK),
    .rst_b (RST_B),
    .bus   (sar)
  );

  assign AWREADY          = awready_q;
  assign WREADY           = wready_q;
  assign BVALID           = bvalid_q;
  assign BRESP            = bresp_q;
  assign ARREADY          = arready_q;
  assign RVALID           = rvalid_q;
  assign RRESP            = rresp_q;
  assign RDATA            = rdata_q;
  assign CHANNEL_SELECT   = chan_q;
  assign CONVERTER_ENABLE = en_q;
  assign SAMPLE_HOLD      = sar.sample_hold;
  assign DAC_CODE         = sar.dac_code;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);

  sequence s_low_then_wait;
    rd_low ##1 (!rd_high && !on_fall);
  endsequence

  sequence s_off_written;
    wr_csr && !w_byte_q[ON_BIT];
  endsequence

  property p_done_set;
    done_accept |=> done_q;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set on completion"); // RULE_03

  property p_high_read_clears;
    (rd_high && !done_accept) |=> !done_q;
  endproperty
  a_high_read_clears: assert property (p_high_read_clears) else $error("high read left done set"); // RULE_04

  property p_write_clears;
    (wr_csr && !done_accept) |=> !done_q && ctrl_q == $past(w_byte_q[6:0]);
  endproperty
  a_write_clears: assert property (p_write_clears) else $error("control write mishandled"); // RULE_05

  property p_lock_holds;
    s_low_then_wait |-> lock_q && $stable(result_q);
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("result changed while locked"); // RULE_11

  property p_lock_release;
    (rd_high || on_fall) |=> !lock_q;
  endproperty
  a_lock_release: assert property (p_lock_release) else $error("lock not released"); // RULE_10

  property p_off_stops;
    s_off_written |-> ##2 !CONVERTER_ENABLE && !SAMPLE_HOLD;
  endproperty
  a_off_stops: assert property (p_off_stops) else $error("converter still running after off"); // RULE_02

  property p_chan_restart;
    chan_change |=> !SAMPLE_HOLD && DAC_CODE == RESULT_RESET ##1 CHANNEL_SELECT == $past(ctrl_q[3:0]);
  endproperty
  a_chan_restart: assert property (p_chan_restart) else $error("channel change did not restart"); // RULE_07

  property p_div4;
    (tick_q && ctrl_q[SLOW_BIT] && !ctrl_q[SPEED_BIT] && !wr_csr) |=> !tick_q;
  endproperty
  a_div4: assert property (p_div4) else $error("divide by four ticked early"); // RULE_12

  property p_undivided;
    (!ctrl_q[SLOW_BIT] && ctrl_q[SPEED_BIT])[*2] |-> tick_q;
  endproperty
  a_undivided: assert property (p_undivided) else $error("undivided clock missed a tick"); // RULE_12

  property p_halt_stops;
    HALT_MODE |=> !CONVERTER_ENABLE;
  endproperty
  a_halt_stops: assert property (p_halt_stops) else $error("converter enabled in halt"); // RULE_18

endmodule // adc_control
`default_nettype wire

// *** core/adc_pkg.sv ***
// Purpose: shared constants and types of the converter control logic
// Assumes: 32-bit register bus, 12-bit byte address
// Notes:   register offsets are word indices, byte address is four times the index
package adc_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int              AXI_ADDR_W   = 12;
  localparam int              AXI_DATA_W   = 32;
  localparam logic [7:0]      CSR_INDEX    = 8'h45;
  localparam logic [7:0]      HIGH_INDEX   = 8'h46;
  localparam logic [7:0]      LOW_INDEX    = 8'h47;
  localparam logic [11:0]     CSR_ADDR     = {2'b00, CSR_INDEX, 2'b00};
  localparam logic [11:0]     HIGH_ADDR    = {2'b00, HIGH_INDEX, 2'b00};
  localparam logic [11:0]     LOW_ADDR     = {2'b00, LOW_INDEX, 2'b00};
  localparam logic [1:0]      RESP_OKAY    = 2'b00;
  localparam logic [1:0]      RESP_SLVERR  = 2'b10;

  // ----------------------------------------------------------------
  // control/status fields and reset values
  // ----------------------------------------------------------------
  localparam int              DONE_BIT     = 7;
  localparam int              SPEED_BIT    = 6;
  localparam int              ON_BIT       = 5;
  localparam int              SLOW_BIT     = 4;
  localparam int              CH_MSB       = 3;
  localparam int              CH_LSB       = 0;
  localparam logic [6:0]      CTRL_RESET   = 7'h00;
  localparam int              RESULT_W     = 10;
  localparam logic [9:0]      RESULT_RESET = 10'h000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int              SAMPLE_TICKS_DEFAULT = 4;
  localparam int              CPU_UNDIVIDED_MAX_HZ = 4_000_000;

  typedef enum logic [1:0] {
    SEQ_IDLE    = 2'b00,
    SEQ_SAMPLE  = 2'b01,
    SEQ_CONVERT = 2'b11
  } seq_state_type;

  // terminal count of the converter clock divider from {slow, speed}
  function automatic logic [1:0] div_limit(input logic slow, input logic speed);
    unique case ({slow, speed})
      2'b00:   div_limit = 2'h1;
      2'b01:   div_limit = 2'h0;
      2'b10:   div_limit = 2'h3;
      default: div_limit = 2'h1;
    endcase
  endfunction

endpackage

// *** core/sar_if.sv ***
// Purpose: link between register logic and approximation sequencer
// Assumes: one clock domain
// Notes:   restart is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface sar_if #(parameter int W = 10);
  logic         tick;
  logic         run;
  logic         restart;
  logic         comp_high;
  logic         sample_hold;
  logic         done;
  logic [W-1:0] dac_code;
  logic [W-1:0] result;

  modport ctrl (output tick, output run, output restart, output comp_high,
                input sample_hold, input done, input dac_code, input result);
  modport seq  (input tick, input run, input restart, input comp_high,
                output sample_hold, output done, output dac_code, output result);
endinterface
`default_nettype wire

// *** core/sar_sequencer.sv ***
// Purpose: sample phase and bitwise successive approximation
// Assumes: tick is a one-cycle converter clock enable
// Notes:   restarts on every completion, so conversion is continuous
`timescale 1ns/1ps
`default_nettype none
module sar_sequencer #(
  parameter int SAMPLE_TICKS = adc_pkg::SAMPLE_TICKS_DEFAULT
) (
  input wire logic clock,
  input wire logic rst_b,
  sar_if.seq       bus
);
  import adc_pkg::*;

  localparam logic [7:0] SAMPLE_LAST = 8'(SAMPLE_TICKS - 1);
  localparam logic [3:0] MSB_IDX     = 4'(RESULT_W - 1);

  seq_state_type         state_q;
  logic [7:0]            cnt_q;
  logic [3:0]            idx_q;
  logic [RESULT_W-1:0]   dac_q;
  logic [RESULT_W-1:0]   trial;
  logic [RESULT_W-1:0]   result_q;
  logic                  sample_q;
  logic                  done_q;

  // keep the trial bit only when the input is at or above it
  always_comb begin
    trial = dac_q;
    if (!bus.comp_high) begin
      trial[idx_q] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q  <= SEQ_IDLE;
      cnt_q    <= 8'h00;
      idx_q    <= 4'h0;
      dac_q    <= RESULT_RESET;
      sample_q <= 1'b0;
      done_q   <= 1'b0;
    end else if (bus.restart || !bus.run) begin // RULE_02 RULE_07
      state_q  <= SEQ_IDLE;
      cnt_q    <= 8'h00;
      dac_q    <= RESULT_RESET;
      sample_q <= 1'b0;
      done_q   <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (bus.tick) begin
        unique case (state_q)
          SEQ_IDLE: begin
            state_q  <= SEQ_SAMPLE;
            sample_q <= 1'b1;
            cnt_q    <= 8'h00;
          end
          SEQ_SAMPLE: begin // RULE_20
            if (cnt_q == SAMPLE_LAST) begin
              state_q  <= SEQ_CONVERT;
              sample_q <= 1'b0;
              idx_q    <= MSB_IDX;
              dac_q    <= RESULT_W'(1) << MSB_IDX;
            end else begin
              cnt_q <= cnt_q + 8'h01;
            end
          end
          SEQ_CONVERT: begin
            if (idx_q == 4'h0) begin // RULE_01 RULE_19
              done_q   <= 1'b1;
              state_q  <= SEQ_SAMPLE;
              sample_q <= 1'b1;
              cnt_q    <= 8'h00;
              dac_q    <= RESULT_RESET;
            end else begin
              dac_q <= trial | (RESULT_W'(1) << 4'(idx_q - 4'h1));
              idx_q <= 4'(idx_q - 4'h1);
            end
          end
          default: begin
            state_q  <= SEQ_IDLE;
            sample_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // result of the last completed approximation
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      result_q <= RESULT_RESET;
    end else if (bus.run && !bus.restart && bus.tick && state_q == SEQ_CONVERT && idx_q == 4'h0) begin
      result_q <= trial;
    end
  end

  assign bus.sample_hold = sample_q;
  assign bus.done        = done_q;
  assign bus.dac_code    = dac_q;
  assign bus.result      = result_q;

endmodule // sar_sequencer
`default_nettype wire

// *** tb/analog_front_model.sv ***
// Purpose: analog inputs behind the channel multiplexer plus comparator
// Assumes: one fixed level per channel
// Notes:   channel 0 sits below and channel 15 above the references
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
  input  wire logic [3:0] CHANNEL_SELECT,
  input  wire logic [9:0] DAC_CODE,
  input  wire logic       CONVERTER_ENABLE,
  output logic            COMP_HIGH
);
  // --------------------------------
  // comparator
  // --------------------------------
  logic [9:0] level;
  always_comb begin
    // clipped at both rails, no overflow sign
    level = (CHANNEL_SELECT == 4'hF) ? 10'h3FF : {CHANNEL_SELECT, 6'h2A};
    if (CHANNEL_SELECT == 4'h0) begin
      level = 10'h000;
    end
  end
  // unpowered comparator decides nothing, so it flips with the trial
  assign COMP_HIGH = CONVERTER_ENABLE ? (level >= DAC_CODE) : ~DAC_CODE[0];
endmodule  // analog_front_model
`default_nettype wire

// *** tb/test_sar_adc_control_logic.sv ***
// Purpose: self-checking bench of the converter control logic
// Assumes: AXI4-Lite master tasks, analog model on the comparator
// Notes:   handshakes sampled at the falling edge, driven after the rising
`timescale 1ns/1ps
`default_nettype none
module test_sar_adc_control_logic;
  import adc_pkg::*;
  logic        CLOCK, RST_B, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY, COMP_HIGH, HALT_MODE, CONVERTER_ENABLE, SAMPLE_HOLD;
  logic [11:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [3:0]  WSTRB, CHANNEL_SELECT;
  logic [1:0]  BRESP, RRESP;
  logic [9:0]  DAC_CODE;
  int          err_total, n_compared;

  adc_control i_adc_control (.CLOCK, .RST_B, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
    .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
    .RREADY, .COMP_HIGH, .HALT_MODE, .CHANNEL_SELECT, .CONVERTER_ENABLE, .SAMPLE_HOLD, .DAC_CODE);
  analog_front_model i_analog_front_model (.CHANNEL_SELECT, .DAC_CODE, .CONVERTER_ENABLE, .COMP_HIGH);

  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end

  // --------------------------------
  // bus and check helpers
  // --------------------------------
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic hang();
    $display("wait limit reached t=%0t", $time);
    err_total++;
    tally_and_finish();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bit         ta, tw, h;
    logic [1:0] r;
    h = 0;
    @(posedge CLOCK);
    AWADDR  <= a;
    WDATA   <= d;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    for (int n = 0; n < 50 && !h; n++) begin
      @(negedge CLOCK);
      ta = AWREADY === 1'b1;
      tw = WREADY === 1'b1;
      h  = BVALID === 1'b1;
      r  = BRESP;
      @(posedge CLOCK);
      if (ta) AWVALID <= 1'b0;
      if (tw) WVALID <= 1'b0;
      if (h) BREADY <= 1'b0;
    end
    if (!h) hang();
    chk({30'h0, r}, {30'h0, (a == 12'h000) ? RESP_SLVERR : RESP_OKAY});
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
    bit ta, h;
    h = 0;
    @(posedge CLOCK);
    ARADDR  <= a;
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    for (int n = 0; n < 50 && !h; n++) begin
      @(negedge CLOCK);
      ta = ARREADY === 1'b1;
      h  = RVALID === 1'b1;
      v  = RDATA;
      r  = RRESP;
      @(posedge CLOCK);
      if (ta) ARVALID <= 1'b0;
      if (h) RREADY <= 1'b0;
    end
    if (!h) hang();
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0]  r;
    rd(a, v, r);
    chk(v, e);
  endtask
  task automatic wait_done();
    logic [31:0] v;
    logic [1:0]  r;
    v = 32'h0;
    for (int n = 0; n < 100 && v[7] !== 1'b1; n++) rd(CSR_ADDR, v, r);
    if (v[7] !== 1'b1) hang();
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_reset_and_map();
    logic [31:0] v;
    logic [1:0]  r;
    rc(CSR_ADDR, 32'h0);
    rc(HIGH_ADDR, 32'h0);
    rc(LOW_ADDR, 32'h0);
    rd(12'h000, v, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk(v, 32'h0);
    wr(12'h000, 32'hFF);
    wr(HIGH_ADDR, 32'hFF);
    rc(HIGH_ADDR, 32'h0);
    // lane 0 off: the write is answered but changes nothing
    WSTRB <= 4'hE;
    wr(CSR_ADDR, 32'h25);
    rc(CSR_ADDR, 32'h0);
    WSTRB <= 4'hF;
  endtask
  task automatic t_modes();
    logic [3:0] chs [4] = '{4'h0, 4'hF, 4'h9, 4'h3};
    logic [9:0] e;
    for (int i = 0; i < 4; i++) begin
      e = (chs[i] == 4'hF) ? 10'h3FF : ((chs[i] == 4'h0) ? 10'h000 : {chs[i], 6'h2A});
      wr(CSR_ADDR, {25'h0, i[0], 1'b1, i[1], chs[i]});
      wait_done();
      rc(LOW_ADDR, {30'h0, e[1:0]});
      rc(HIGH_ADDR, {24'h0, e[9:2]});
    end
  endtask
  task automatic t_lock();
    wr(CSR_ADDR, 32'h39);
    wait_done();
    rc(LOW_ADDR, 32'h2);
    wr(CSR_ADDR, 32'h33);
    rc(CSR_ADDR, 32'h33);
    repeat (200) @(posedge CLOCK);
    // halt freezes completions, so no new done can race the flag checks
    HALT_MODE <= 1'b1;
    rc(CSR_ADDR, 32'hB3);
    rc(HIGH_ADDR, 32'h9A);
    rc(CSR_ADDR, 32'h33);
    HALT_MODE <= 1'b0;
    wait_done();
    rc(HIGH_ADDR, 32'h3A);
    wait_done();
    HALT_MODE <= 1'b1;
    wr(CSR_ADDR, 32'hB3);
    rc(CSR_ADDR, 32'h33);
    HALT_MODE <= 1'b0;
  endtask
  task automatic t_off_and_halt();
    rc(LOW_ADDR, 32'h2);
    wr(CSR_ADDR, 32'h09);
    repeat (150) @(negedge CLOCK);
    chk({31'h0, CONVERTER_ENABLE}, 32'h0);
    chk({31'h0, SAMPLE_HOLD}, 32'h0);
    chk({22'h0, DAC_CODE}, 32'h0);
    chk({28'h0, CHANNEL_SELECT}, 32'h9);
    rc(CSR_ADDR, 32'h09);
    wr(CSR_ADDR, 32'h39);
    wait_done();
    rc(HIGH_ADDR, 32'h9A);
    @(posedge CLOCK);
    HALT_MODE <= 1'b1;
    repeat (3) @(negedge CLOCK);
    chk({31'h0, CONVERTER_ENABLE}, 32'h0);
    @(posedge CLOCK);
    HALT_MODE <= 1'b0;
    repeat (3) @(negedge CLOCK);
    chk({31'h0, CONVERTER_ENABLE}, 32'h1);
  endtask

  initial begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, HALT_MODE, RST_B} = '0;
    AWADDR     = 12'h0;
    ARADDR     = 12'h0;
    WDATA      = 32'h0;
    WSTRB      = 4'hF;
    err_total  = 0;
    n_compared = 0;
    repeat (20) @(posedge CLOCK);
    RST_B <= 1'b1;
    t_reset_and_map();
    t_modes();
    t_lock();
    t_off_and_halt();
    tally_and_finish();
  end
endmodule  // test_sar_adc_control_logic
`default_nettype wire
